// ==== verilog/rcb_defines.svh ====
// Register offsets, field positions and reset values of the receive
// cell-bus status drive block. Included by the package and by the block.
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

// ==========================================================
// Register word offsets on the plain register port
`define RCB_OFF_CFG 4'h0
`define RCB_OFF_CFG2 4'h1
`define RCB_OFF_WM 4'h2
`define RCB_OFF_STAT 4'h3

// ==========================================================
// Common configuration word: fields and reset value
`define RCB_B_EOFQ 6
`define RCB_B_DIRECT 5
`define RCB_B_SHARE 4
`define RCB_CFG_RST 16'h0024
`define RCB_CFG_MASK 16'h0fff

// ==========================================================
// Second configuration word: base address, bus level, packet mode
`define RCB_B_BASE_HI 2
`define RCB_B_BASE_LO 0
`define RCB_B_LEVEL3 3
`define RCB_B_PKT 4
`define RCB_CFG2_RST 16'h0010
`define RCB_CFG2_MASK 16'h001f

// ==========================================================
// Far-end address fields: device number above, channel below
`define RCB_A_DEV_HI 4
`define RCB_A_DEV_LO 2
`define RCB_A_CHAN_HI 1
`define RCB_A_CHAN_LO 0

// ==========================================================
// Watermark reset value, zero word
`define RCB_WM_RST 16'h0001
`define RCB_ZERO16 16'h0000

`endif

// ==== verilog/rcb_pkg.sv ====
// Types shared by the receive cell-bus status drive block.
// Assumes rcb_defines.svh sits on the include path.
`include "rcb_defines.svh"

package rcb_pkg;

    // Register data word
    typedef logic [15:0] rcb_word_t;

    // Per-channel FIFO word counts, channel 3 in the top word
    typedef logic [3:0][15:0] rcb_cnt_t;

    // Configuration bundle handed across to the link clock domain
    typedef struct packed {
        logic eofq;
        logic direct;
        logic share;
        logic level3;
        logic pkt;
        logic [2:0] base;
        rcb_word_t wm;
    } rcb_cfg_s;

endpackage

// ==== verilog/rcb_status_drive.sv ====
// Receive cell-bus status drive: configuration registers and the output
// enables of the fifo-available, polled status and receive data pins.
// Assumes the FIFO status inputs and the far-end address and enable come
// from logic on the link clock; pads resolve high impedance from the *_oe.
//
// Contract
// - Packet mode, qualifier 0: avail when end-of-frame stored or count reaches watermark.
// - Qualifier 1: avail only when count reaches the watermark.
// - Four independent fifo-available outputs, channels 0 to 3.
// - Direct status select 1: all four avail outputs driven always.
// - Direct select 0: driven one (level 2) or two (level 3) cycles after address hit.
// - Polling qualified by address equal to the three-bit base; far end presents it.
// - Sharing 1: used receive outputs driven only while selected.
// - Sharing 1: polled avail driven only while address matches device address.
// - Sharing 0: data, frame start, parity and polled avail outputs driven always.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "rcb_defines.svh"

module rcb_status_drive (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire rcb_pkg::rcb_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output rcb_pkg::rcb_word_t reg_rdata,
    input wire logic rx_clk,
    input wire logic [4:0] rx_addr,
    input wire logic rx_enb_n,
    input wire logic [3:0] chan_eof_present,
    input wire rcb_pkg::rcb_cnt_t chan_word_count,
    output logic [3:0] rx_chan_fifo_avail,
    output logic [3:0] rx_chan_fifo_avail_oe,
    output logic rx_polled_fifo_avail,
    output logic rx_polled_fifo_avail_oe,
    output logic rx_bus_oe
);
    import rcb_pkg::*;

    // Availability of one channel from its FIFO level and the configuration
    function automatic logic avail_f(input rcb_cfg_s c, input logic eof, input rcb_word_t cnt);
        avail_f = (c.pkt && !c.eofq && eof) || (cnt >= c.wm);
    endfunction

    // Bundle as it stands after reset, built from the reset words so both sides agree
    localparam rcb_word_t CFG_RST_W = `RCB_CFG_RST;
    localparam rcb_word_t CFG2_RST_W = `RCB_CFG2_RST;
    localparam rcb_cfg_s BUNDLE_RST = '{eofq: CFG_RST_W[`RCB_B_EOFQ],
        direct: CFG_RST_W[`RCB_B_DIRECT], share: CFG_RST_W[`RCB_B_SHARE],
        level3: CFG2_RST_W[`RCB_B_LEVEL3], pkt: CFG2_RST_W[`RCB_B_PKT],
        base: CFG2_RST_W[`RCB_B_BASE_HI:`RCB_B_BASE_LO], wm: `RCB_WM_RST};

    // ==========================================================
    // Register file on the system clock

    rcb_word_t cfg_r;
    rcb_word_t cfg2_r;
    rcb_word_t wm_r;
    rcb_word_t rdata_r;
    rcb_cfg_s bundle_r;
    logic tgl_r;
    logic [3:0] st_s1_r;
    logic [3:0] st_s2_r;
    // Link-side avail levels, declared here since the status synchroniser reads them
    logic [3:0] avail_r;

    // Address decode and next values
    wire logic hit_cfg = reg_addr == `RCB_OFF_CFG;
    wire logic hit_cfg2 = reg_addr == `RCB_OFF_CFG2;
    wire logic hit_wm = reg_addr == `RCB_OFF_WM;
    wire logic hit_stat = reg_addr == `RCB_OFF_STAT;
    wire logic cfg_wr = reg_wr && (hit_cfg || hit_cfg2 || hit_wm);
    wire rcb_word_t cfg_nxt = (reg_wr && hit_cfg) ? (reg_wdata & `RCB_CFG_MASK) : cfg_r;
    wire rcb_word_t cfg2_nxt = (reg_wr && hit_cfg2) ? (reg_wdata & `RCB_CFG2_MASK) : cfg2_r;
    wire rcb_word_t wm_nxt = (reg_wr && hit_wm) ? reg_wdata : wm_r;
    wire rcb_word_t stat_word = {12'h000, st_s2_r};
    wire rcb_word_t rd_sel = hit_cfg ? cfg_r : hit_cfg2 ? cfg2_r : hit_wm ? wm_r :
                             hit_stat ? stat_word : `RCB_ZERO16;
    wire rcb_word_t rdata_nxt = reg_rd ? rd_sel : `RCB_ZERO16;

    // Bundle of the new values, held stable until the next write
    rcb_cfg_s bundle_nxt;
    always_comb begin
        bundle_nxt.eofq = cfg_nxt[`RCB_B_EOFQ];
        bundle_nxt.direct = cfg_nxt[`RCB_B_DIRECT];
        bundle_nxt.share = cfg_nxt[`RCB_B_SHARE];
        bundle_nxt.level3 = cfg2_nxt[`RCB_B_LEVEL3];
        bundle_nxt.pkt = cfg2_nxt[`RCB_B_PKT];
        bundle_nxt.base = cfg2_nxt[`RCB_B_BASE_HI:`RCB_B_BASE_LO];
        bundle_nxt.wm = wm_nxt;
    end

    // Registers, read data for one cycle, and the toggle that announces a new bundle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= `RCB_CFG_RST;
            cfg2_r <= `RCB_CFG2_RST;
            wm_r <= `RCB_WM_RST;
            rdata_r <= `RCB_ZERO16;
            tgl_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cfg2_r <= cfg2_nxt;
            wm_r <= wm_nxt;
            rdata_r <= rdata_nxt;
            tgl_r <= tgl_r ^ cfg_wr;
        end
    end

    // Bundle reloads only on a write, so it stands still while the toggle crosses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bundle_r <= BUNDLE_RST;
        end else if (cfg_wr) begin
            bundle_r <= bundle_nxt;
        end
    end

    // Avail state brought back for status reads; each bit is an independent level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_s1_r <= 4'h0;
            st_s2_r <= 4'h0;
        end else begin
            st_s1_r <= avail_r;
            st_s2_r <= st_s1_r;
        end
    end

    assign reg_rdata = rdata_r;

    // ==========================================================
    // Link clock domain

    logic rrst_a_r;
    logic rrst_b_r;
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_seen_r;
    rcb_cfg_s rcfg_r;
    logic hit_d1_r;
    logic [1:0] chan_d1_r;
    logic enb_d_r;
    logic selected_r;
    logic [3:0] fa_r;
    logic [3:0] fa_oe_r;
    logic pfa_r;
    logic pfa_oe_r;
    logic bus_oe_r;

    // Reset release synchronised to the link clock; assertion stays asynchronous
    always_ff @(posedge rx_clk or negedge nrst) begin
        if (!nrst) begin
            rrst_a_r <= 1'b0;
            rrst_b_r <= 1'b0;
        end else begin
            rrst_a_r <= 1'b1;
            rrst_b_r <= rrst_a_r;
        end
    end
    wire logic rnrst = rrst_b_r;

    // Toggle crossing: bundle is stable for several link cycles before the toggle lands
    wire logic cfg_load = tgl_s2_r != tgl_seen_r;
    always_ff @(posedge rx_clk or negedge rnrst) begin
        if (!rnrst) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_seen_r <= 1'b0;
            rcfg_r <= BUNDLE_RST;
        end else begin
            tgl_s1_r <= tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_seen_r <= tgl_s2_r;
            if (cfg_load) begin
                rcfg_r <= bundle_r;
            end
        end
    end

    // Per-channel availability, one evaluation per channel
    logic [3:0] avail_nxt;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            avail_nxt[i] = avail_f(rcfg_r, chan_eof_present[i],
                                   chan_word_count[i]);
        end
    end

    // Address match on the base, polling window per bus level, selection by enable edge
    wire logic addr_hit = rx_addr[`RCB_A_DEV_HI:`RCB_A_DEV_LO] == rcfg_r.base;
    wire logic [1:0] addr_chan = rx_addr[`RCB_A_CHAN_HI:`RCB_A_CHAN_LO];
    wire logic poll_hit = rcfg_r.level3 ? hit_d1_r : addr_hit;
    wire logic [1:0] poll_chan = rcfg_r.level3 ? chan_d1_r : addr_chan;
    wire logic enb_fall = enb_d_r && !rx_enb_n;
    wire logic selected_nxt = enb_fall ? addr_hit : selected_r;
    wire logic fa_oe_nxt = rcfg_r.direct || poll_hit;
    wire logic pfa_oe_nxt = !rcfg_r.share || poll_hit;
    wire logic bus_oe_nxt = !rcfg_r.share || selected_nxt;
    wire logic pfa_nxt = pfa_oe_nxt && avail_nxt[poll_chan];

    // Output flops; a released pin also carries zero in its value flop
    always_ff @(posedge rx_clk or negedge rnrst) begin
        if (!rnrst) begin
            avail_r <= 4'h0;
            hit_d1_r <= 1'b0;
            chan_d1_r <= 2'b00;
            enb_d_r <= 1'b1;
            selected_r <= 1'b0;
            fa_r <= 4'h0;
            fa_oe_r <= 4'h0;
            pfa_r <= 1'b0;
            pfa_oe_r <= 1'b0;
            bus_oe_r <= 1'b0;
        end else begin
            avail_r <= avail_nxt;
            hit_d1_r <= addr_hit;
            chan_d1_r <= addr_chan;
            enb_d_r <= rx_enb_n;
            selected_r <= selected_nxt;
            fa_r <= fa_oe_nxt ? avail_nxt : 4'h0;
            fa_oe_r <= {4{fa_oe_nxt}};
            pfa_r <= pfa_nxt;
            pfa_oe_r <= pfa_oe_nxt;
            bus_oe_r <= bus_oe_nxt;
        end
    end

    assign rx_chan_fifo_avail = fa_r;
    assign rx_chan_fifo_avail_oe = fa_oe_r;
    assign rx_polled_fifo_avail = pfa_r;
    assign rx_polled_fifo_avail_oe = pfa_oe_r;
    assign rx_bus_oe = bus_oe_r;

    // ==========================================================
    // Assertions, link clock domain

    // In packet mode with qualifier 0, every channel holding an end-of-frame must show avail, whatever its count
    property p_avail_eof;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.pkt && !rcfg_r.eofq)
            |=> ((avail_r & $past(chan_eof_present)) == $past(chan_eof_present));
    endproperty
    a_avail_eof: assert property (p_avail_eof) else $error("eof did not raise avail");

    // Channel 2 holds an end-of-frame below the watermark: the qualifier must mask it
    property p_avail_wm_only;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.eofq && (chan_word_count[2] < rcfg_r.wm)) |=> !avail_r[2];
    endproperty
    a_avail_wm_only: assert property (p_avail_wm_only)
        else $error("avail without watermark");

    property p_avail_wm;
        @(posedge rx_clk) disable iff (!rnrst)
        (chan_word_count[0] >= rcfg_r.wm) |=> avail_r[0];
    endproperty
    a_avail_wm: assert property (p_avail_wm)
        else $error("watermark did not raise avail");

    property p_chan_indep;
        @(posedge rx_clk) disable iff (!rnrst)
        (chan_word_count[2] >= rcfg_r.wm && chan_word_count[3] < rcfg_r.wm
         && !chan_eof_present[3]) |=> (avail_r[2] && !avail_r[3]);
    endproperty
    a_chan_indep: assert property (p_chan_indep) else $error("channel avail bits mixed");

    property p_direct_drive;
        @(posedge rx_clk) disable iff (!rnrst)
        rcfg_r.direct ##1 $stable(rcfg_r) |-> (rx_chan_fifo_avail_oe == 4'hf)
            && (rx_chan_fifo_avail == $past(avail_nxt));
    endproperty
    a_direct_drive: assert property (p_direct_drive)
        else $error("direct mode not driving");

    property p_poll_l2;
        @(posedge rx_clk) disable iff (!rnrst)
        (!rcfg_r.direct && !rcfg_r.level3 && addr_hit) ##1 $stable(rcfg_r)
            |-> rx_chan_fifo_avail_oe[0];
    endproperty
    a_poll_l2: assert property (p_poll_l2) else $error("level 2 poll not one cycle");

    property p_poll_l3;
        @(posedge rx_clk) disable iff (!rnrst)
        (!rcfg_r.direct && rcfg_r.level3 && !hit_d1_r && addr_hit) ##1 $stable(rcfg_r)
            |-> !rx_chan_fifo_avail_oe[0] ##1 rx_chan_fifo_avail_oe[0];
    endproperty
    a_poll_l3: assert property (p_poll_l3) else $error("level 3 poll not two cycles");

    property p_poll_base;
        @(posedge rx_clk) disable iff (!rnrst)
        (!rcfg_r.direct && !rcfg_r.level3 && !addr_hit) ##1 $stable(rcfg_r)
            |-> !rx_chan_fifo_avail_oe[1];
    endproperty
    a_poll_base: assert property (p_poll_base) else $error("driven without base match");

    property p_share_sel;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.share && rx_enb_n && !selected_r) ##1 $stable(rcfg_r) |-> !rx_bus_oe;
    endproperty
    a_share_sel: assert property (p_share_sel)
        else $error("bus driven while unselected");

    property p_share_select;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.share && enb_fall && addr_hit) ##1 $stable(rcfg_r) |-> rx_bus_oe;
    endproperty
    a_share_select: assert property (p_share_select)
        else $error("selected device not driving");

    // Level 3 polled status waits one extra cycle behind the address
    property p_poll_pfa_l3;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.share && !rcfg_r.direct && rcfg_r.level3 && !hit_d1_r && addr_hit)
            ##1 $stable(rcfg_r) |-> !rx_polled_fifo_avail_oe ##1 rx_polled_fifo_avail_oe;
    endproperty
    a_poll_pfa_l3: assert property (p_poll_pfa_l3)
        else $error("level 3 polled avail off time");

    property p_share_pfa;
        @(posedge rx_clk) disable iff (!rnrst)
        (rcfg_r.share && !rcfg_r.level3 && !addr_hit) ##1 $stable(rcfg_r)
            |-> !rx_polled_fifo_avail_oe;
    endproperty
    a_share_pfa: assert property (p_share_pfa)
        else $error("polled avail driven off address");

    property p_solo_drive;
        @(posedge rx_clk) disable iff (!rnrst)
        !rcfg_r.share ##1 $stable(rcfg_r) |-> rx_bus_oe && rx_polled_fifo_avail_oe;
    endproperty
    a_solo_drive: assert property (p_solo_drive) else $error("sole device not driving");

    property p_release_zero;
        @(posedge rx_clk) disable iff (!rnrst)
        !rx_polled_fifo_avail_oe |-> !rx_polled_fifo_avail;
    endproperty
    a_release_zero: assert property (p_release_zero)
        else $error("released pin carries value");

    // Main scenarios
    c_level3_poll: cover property (@(posedge rx_clk) disable iff (!rnrst)
        rcfg_r.level3 && !rcfg_r.direct && rx_chan_fifo_avail_oe[0] && rx_chan_fifo_avail[0]);
    c_shared_select: cover property (@(posedge rx_clk) disable iff (!rnrst)
        rcfg_r.share && enb_fall && addr_hit);
    c_eof_avail: cover property (@(posedge rx_clk) disable iff (!rnrst)
        !rcfg_r.eofq && avail_r[2] && chan_word_count[2] < rcfg_r.wm);

    // ==========================================================
    // Assertion, system clock domain

    property p_read_once;
        @(posedge clk) disable iff (!nrst)
        (reg_rd && hit_cfg) |=> (reg_rdata == $past(cfg_r));
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data not next cycle");

    c_cfg_write: cover property (@(posedge clk) disable iff (!nrst) reg_wr && hit_cfg);

endmodule // rcb_status_drive

// ==== tb/rcb_far_end.sv ====
// Far-end link layer model: drives the link address and the enable.
// Assumes it shares the link clock with the block and changes just after edges.
`timescale 1ns/1ps

module rcb_far_end (
    input wire logic rx_clk,
    output logic [4:0] rx_addr,
    output logic rx_enb_n
);
    // Idle: enable high, address on device number 7, the base here only after the all-ones write
    initial begin
        rx_addr = 5'h1f;
        rx_enb_n = 1'b1;
    end

    // One link cycle of address and enable, launched after an edge
    task automatic present(input logic [4:0] a, input logic enb_n);
        @(posedge rx_clk);
        rx_addr <= a;
        rx_enb_n <= enb_n;
    endtask
endmodule // rcb_far_end

// ==== tb/rcb_status_drive_tb_top.sv ====
// Testbench: register table, status drive modes, polling and selection.
// Assumes the far-end model owns the link address and the enable.
`timescale 1ns/1ps
`include "rcb_defines.svh"

module rcb_status_drive_tb_top;
    import rcb_pkg::*;
    logic clk = 1'b0;
    logic rx_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    rcb_word_t reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    rcb_word_t reg_rdata;
    logic [4:0] rx_addr;
    logic rx_enb_n;
    logic [3:0] eof = 4'h4;
    rcb_cnt_t cnt = {16'h0000, 16'h0003, 16'h0004, 16'h0003};
    logic [3:0] fa, fa_oe;
    logic pfa, pfa_oe, bus_oe;
    rcb_word_t rd;
    int mismatches = 0;
    int n_tests = 0;

    // Link clock period differs, so its phase against clk alternates between two offsets
    always #5 clk = ~clk;
    always #7.5 rx_clk = ~rx_clk;

    rcb_status_drive i_rcb_status_drive (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_clk(rx_clk), .rx_addr(rx_addr), .rx_enb_n(rx_enb_n),
        .chan_eof_present(eof), .chan_word_count(cnt), .rx_chan_fifo_avail(fa),
        .rx_chan_fifo_avail_oe(fa_oe), .rx_polled_fifo_avail(pfa),
        .rx_polled_fifo_avail_oe(pfa_oe), .rx_bus_oe(bus_oe));
    rcb_far_end i_rcb_far_end (.rx_clk(rx_clk), .rx_addr(rx_addr), .rx_enb_n(rx_enb_n));

    // ==========================================================
    // Register port tasks
    // Writes wait 10 link edges: the crossing must not see two in flight
    task automatic reg_write(input logic [3:0] a, input rcb_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (10) @(posedge rx_clk);
        #1;
    endtask

    task automatic reg_read(input logic [3:0] a, output rcb_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // ==========================================================
    // Comparisons
    task automatic chk_reg(input string nm, input rcb_word_t e, input rcb_word_t g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input rcb_word_t e);
        reg_read(a, rd);
        chk_reg("reg_rdata", e, rd);
    endtask

    // Mode bits: c = {eofq, direct, share}; c2 = {pkt, level3, base}
    task automatic setup(input logic [2:0] c, input logic [4:0] c2);
        reg_write(`RCB_OFF_CFG, {9'h000, c, 4'h0});
        reg_write(`RCB_OFF_CFG2, {11'h000, c2});
    endtask

    // Poll one address; level 3 must still be released one edge in
    task automatic poll_chk(input logic [4:0] a, input int lat, input logic e_pfa);
        i_rcb_far_end.present(a, 1'b1);
        if (lat == 2) begin
            @(posedge rx_clk);
            #1 chk_pin("fa_oe early", 4'h0, fa_oe);
        end
        @(posedge rx_clk);
        #1 chk_pin("fa_oe", 4'hf, fa_oe);
        chk_pin("fa", 4'h7, fa);
        chk_pin("pfa_oe", 4'h1, {3'h0, pfa_oe});
        chk_pin("pfa", {3'h0, e_pfa}, {3'h0, pfa});
    endtask

    // Enable falls on the given address; selection shows on the next edge
    task automatic sel_chk(input logic [4:0] a, input logic e);
        i_rcb_far_end.present(a, 1'b1);
        i_rcb_far_end.present(a, 1'b0);
        @(posedge rx_clk);
        #1 chk_pin("bus_oe", {3'h0, e}, {3'h0, bus_oe});
    endtask

    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the sequence needs well under 20 us
    initial begin
        #50000;
        mismatches++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        // Three cycles so that both clocks see the reset at least twice
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`RCB_OFF_CFG, `RCB_CFG_RST);
        rd_chk(`RCB_OFF_CFG2, `RCB_CFG2_RST);
        rd_chk(`RCB_OFF_WM, `RCB_WM_RST);
        reg_write(4'h7, 16'hffff);
        rd_chk(4'h7, 16'h0000);
        reg_write(`RCB_OFF_CFG, 16'hffff);
        rd_chk(`RCB_OFF_CFG, `RCB_CFG_MASK);
        reg_write(`RCB_OFF_CFG2, 16'hffff);
        rd_chk(`RCB_OFF_CFG2, `RCB_CFG2_MASK);
        reg_write(`RCB_OFF_WM, 16'h0004);
        rd_chk(`RCB_OFF_WM, 16'h0004);
        // Sole device, direct status: counts 3,4,3,0 against watermark 4
        setup(3'b010, 5'h10);
        chk_pin("fa", 4'h6, fa);
        chk_pin("fa_oe", 4'hf, fa_oe);
        chk_pin("bus_oe", 4'h1, {3'h0, bus_oe});
        chk_pin("pfa_oe", 4'h1, {3'h0, pfa_oe});
        rd_chk(`RCB_OFF_STAT, 16'h0006);
        setup(3'b110, 5'h10);
        chk_pin("fa", 4'h2, fa);
        setup(3'b010, 5'h00);
        chk_pin("fa", 4'h2, fa);
        // Channel 0 reaches the watermark alone; the others stay put
        @(posedge rx_clk);
        cnt[0] <= 16'h0004;
        setup(3'b010, 5'h10);
        chk_pin("fa", 4'h7, fa);
        // Shared bus, direct: avail pins stay driven, data group released
        i_rcb_far_end.present(5'h11, 1'b1);
        setup(3'b011, 5'h15);
        chk_pin("fa_oe", 4'hf, fa_oe);
        chk_pin("bus_oe", 4'h0, {3'h0, bus_oe});
        // Polled, shared, base 5: device 4 on the address drives nothing
        setup(3'b001, 5'h15);
        chk_pin("fa_oe", 4'h0, fa_oe);
        chk_pin("fa", 4'h0, fa);
        chk_pin("pfa_oe", 4'h0, {3'h0, pfa_oe});
        poll_chk(5'h15, 1, 1'b1);
        poll_chk(5'h17, 1, 1'b0);
        sel_chk(5'h15, 1'b1);
        sel_chk(5'h11, 1'b0);
        i_rcb_far_end.present(5'h11, 1'b1);
        setup(3'b001, 5'h1d);
        poll_chk(5'h14, 2, 1'b1);
        test_done();
    end
endmodule // rcb_status_drive_tb_top
